//--- core/sadc_pkg.sv
/*
 Shared constants and types for the SAR converter control block.
 Assumes a 32-bit Avalon-MM slave with word-aligned byte addresses.
*/
package sadc_pkg;

    // ==========================================================
    // Register map (byte addresses)
    localparam logic [3:0] SADC_OFF_CTRL   = 4'h0;
    localparam logic [3:0] SADC_OFF_CFG    = 4'h4;
    localparam logic [3:0] SADC_OFF_RESULT = 4'h8;
    localparam logic [3:0] SADC_OFF_STATUS = 4'hC;
    localparam int         SADC_ADDR_W     = 4;

    // ==========================================================
    // Control register fields
    localparam int SADC_CTRL_ON_BIT = 0;
    localparam int SADC_CTRL_GO_BIT = 1;
    localparam int SADC_CTRL_CH_LSB = 2;
    localparam int SADC_CH_W        = 6;

    // ==========================================================
    // Config register fields
    localparam int SADC_CFG_PREF_LSB = 0;
    localparam int SADC_PREF_W       = 2;
    localparam int SADC_CFG_NREF_BIT = 2;
    localparam int SADC_CFG_CLK_LSB  = 4;
    localparam int SADC_CLK_W        = 3;
    localparam int SADC_CFG_MASK_BIT = 8;

    // ==========================================================
    // Status register fields
    localparam int SADC_STAT_DONE_BIT = 0;
    localparam int SADC_STAT_BUSY_BIT = 1;

    // ==========================================================
    // Conversion parameters
    localparam int SADC_RES_W       = 10;
    localparam int SADC_CONV_PERIOD = 11;
    localparam int SADC_HI_W        = 2;
    localparam int SADC_LO_W        = 8;

    // Channel codes for the non-pin sources
    localparam logic [5:0] SADC_CH_TEMP = 6'h3C;
    localparam logic [5:0] SADC_CH_DAC  = 6'h3D;
    localparam logic [5:0] SADC_CH_FVR  = 6'h3E;
    localparam logic [5:0] SADC_CH_GND  = 6'h3F;

    // Positive reference encodings
    localparam logic [1:0] SADC_PREF_PIN    = 2'h0;
    localparam logic [1:0] SADC_PREF_SUPPLY = 2'h1;
    localparam logic [1:0] SADC_PREF_FVR2   = 2'h2;
    localparam logic [1:0] SADC_PREF_FVR4   = 2'h3;

    // Clock select: x11 picks the dedicated RC clock
    localparam logic [1:0] SADC_CLK_RC_LOW = 2'h3;

    typedef struct packed {
        logic [SADC_CH_W-1:0]   channel_select;
        logic [SADC_PREF_W-1:0] pos_ref_select;
        logic                   neg_ref_select;
        logic                   sample_hold;
    } sadc_analog_t;

endpackage : sadc_pkg

//--- core/sadc_sar.sv
/*
 Successive-approximation engine: one bit decided per bit period.
 Assumes the analog comparator answers within one bit period.
*/
`timescale 1ns/1ns
`default_nettype none
module sadc_sar
    import sadc_pkg::*;
#(
    parameter int RES_W = SADC_RES_W
) (
    input  wire logic             clk,
    input  wire logic             reset,
    input  wire logic             start,
    input  wire logic             tick,
    input  wire logic             comp_high,
    output logic      [RES_W-1:0] dac_trial,
    output logic                  hold,
    output logic                  done,
    output logic      [RES_W-1:0] code
);

    logic [RES_W-1:0] bit_mask_ff;
    logic [RES_W-1:0] trial_ff;
    logic [RES_W-1:0] code_ff;
    logic [3:0]       period_ff;
    logic             busy_ff;
    logic             done_ff;

    assign dac_trial = trial_ff;
    assign hold      = busy_ff;
    assign done      = done_ff;
    assign code      = code_ff;

    // ==========================================================
    // Bit sequencing: first period samples, then one per bit
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            busy_ff     <= 1'b0;
            done_ff     <= 1'b0;
            period_ff   <= 4'h0;
            bit_mask_ff <= '0;
            trial_ff    <= '0;
            code_ff     <= '0;
        end else begin
            done_ff <= 1'b0;
            if (start && !busy_ff) begin
                busy_ff     <= 1'b1;
                period_ff   <= 4'h0;
                bit_mask_ff <= {1'b1, {(RES_W-1){1'b0}}};
                trial_ff    <= {1'b1, {(RES_W-1){1'b0}}};
            end else if (busy_ff && tick) begin
                if (period_ff == 4'h0) begin
                    period_ff <= 4'h1;
                end else begin
                    period_ff <= period_ff + 4'h1;
                    if (!comp_high) begin
                        trial_ff <= trial_ff & ~bit_mask_ff;
                    end
                    bit_mask_ff <= bit_mask_ff >> 1;
                    if (bit_mask_ff[0]) begin
                        busy_ff <= 1'b0;
                        done_ff <= 1'b1;
                        code_ff <= comp_high ? trial_ff
                                             : (trial_ff & ~bit_mask_ff);
                    end else begin
                        trial_ff <= (comp_high ? trial_ff
                                     : (trial_ff & ~bit_mask_ff))
                                    | (bit_mask_ff >> 1);
                    end
                end
            end
        end
    end

endmodule : sadc_sar
`default_nettype wire

//--- core/sadc_ctrl.sv
/*
 Control and configuration of a 10-bit SAR converter with an
 Avalon-MM register slave, conversion clock divider and interrupt.
 Assumes an external comparator and trial DAC on the analog side.
*/
// Implementation choices: the address map and register access over Avalon-MM.
// What this block does
// - Ten-bit SAR result into one result register
// - One mux feeds a single sample-hold
// - Completion interrupt, able to wake sleep
// - Six-bit channel select picks the source
// - Two-bit positive reference select, four sources, three on low-voltage parts
// - One bit picks negative reference pin/ground
// - Converter on before go; not same write
// - Done clears go, sets flag, updates results
// - Three-bit clock select: dividers or RC
// - Conversion takes eleven bit periods
`timescale 1ns/1ns
`default_nettype none
module sadc_ctrl
    import sadc_pkg::*;
#(
    parameter int RES_W = SADC_RES_W
) (
    input  wire logic                   clk,
    input  wire logic                   reset,
    input  wire logic [SADC_ADDR_W-1:0] avs_address,
    input  wire logic                   avs_read,
    input  wire logic                   avs_write,
    input  wire logic [31:0]            avs_writedata,
    input  wire logic [3:0]             avs_byteenable,
    output logic      [31:0]            avs_readdata,
    output logic                        avs_waitrequest,
    input  wire logic                   rc_clock_tick,
    input  wire logic                   comp_high,
    input  wire logic                   low_voltage_part,
    output var sadc_analog_t            analog_ctrl,
    output logic      [RES_W-1:0]       dac_trial,
    output logic                        irq
);

    logic                 on_ff;
    logic                 go_ff;
    logic [SADC_CH_W-1:0] chan_ff;
    logic [1:0]           pref_ff;
    logic                 nref_ff;
    logic [2:0]           clksel_ff;
    logic                 mask_ff;
    logic                 flag_ff;
    logic [RES_W-1:0]     result_ff;
    logic [31:0]          rdata_ff;
    logic                 ack_ff;
    logic [5:0]           div_ff;
    logic [5:0]           div_limit;
    logic                 tick;
    logic                 start;
    logic                 sar_hold;
    logic                 sar_done;
    logic [RES_W-1:0]     sar_code;
    logic                 wr_ctrl;
    logic                 wr_cfg;
    logic                 wr_stat;

    // ==========================================================
    // Bus slave: one wait state on every access
    assign avs_waitrequest = (avs_read || avs_write) && !ack_ff;
    assign avs_readdata    = rdata_ff;
    assign wr_ctrl = avs_write && !ack_ff && avs_byteenable[0]
                     && avs_address == SADC_OFF_CTRL;
    assign wr_cfg  = avs_write && !ack_ff
                     && avs_address == SADC_OFF_CFG;
    assign wr_stat = avs_write && !ack_ff && avs_byteenable[0]
                     && avs_address == SADC_OFF_STATUS;

    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            ack_ff <= 1'b0;
        end else begin
            ack_ff <= (avs_read || avs_write) && !ack_ff;
        end
    end

    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            rdata_ff <= 32'h0000_0000;
        end else if (avs_read && !ack_ff) begin
            unique case (avs_address)
                SADC_OFF_CTRL:   rdata_ff <= {24'h00_0000, chan_ff,
                                             go_ff, on_ff};
                SADC_OFF_CFG:    rdata_ff <= {23'h00_0000, mask_ff,
                                             1'b0, clksel_ff, 1'b0,
                                             nref_ff, pref_ff};
                SADC_OFF_RESULT: rdata_ff <= {22'h00_0000,
                                             result_ff};
                SADC_OFF_STATUS: rdata_ff <= {30'h0000_0000,
                                             sar_hold, flag_ff};
                default:         rdata_ff <= 32'h0000_0000;
            endcase
        end
    end

    // ==========================================================
    // Control register: on, go and channel
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            on_ff   <= 1'b0;
            chan_ff <= '0;
        end else if (wr_ctrl) begin
            on_ff   <= avs_writedata[SADC_CTRL_ON_BIT];
            chan_ff <= avs_writedata[SADC_CTRL_CH_LSB +: SADC_CH_W];
        end
    end

    // Go only accepted when already on; done wins over a rewrite
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            go_ff <= 1'b0;
        end else if (sar_done || !on_ff) begin
            go_ff <= 1'b0;
        end else if (wr_ctrl && avs_writedata[SADC_CTRL_GO_BIT]
                     && avs_writedata[SADC_CTRL_ON_BIT]) begin
            go_ff <= 1'b1;
        end
    end

    // Go still reads set in the done cycle; a start there would repeat
    assign start = go_ff && on_ff && !sar_hold && !sar_done;

    // ==========================================================
    // Config register: references, clock, interrupt mask
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            pref_ff   <= SADC_PREF_PIN;
            nref_ff   <= 1'b0;
            clksel_ff <= 3'h0;
            mask_ff   <= 1'b0;
        end else if (wr_cfg) begin
            if (avs_byteenable[0]) begin
                // Upper fixed-reference option missing on low-voltage parts
                if (low_voltage_part && avs_writedata[1:0]
                    == SADC_PREF_FVR4) begin
                    pref_ff <= SADC_PREF_FVR2;
                end else begin
                    pref_ff <= avs_writedata[SADC_CFG_PREF_LSB +:
                                             SADC_PREF_W];
                end
                nref_ff   <= avs_writedata[SADC_CFG_NREF_BIT];
                clksel_ff <= avs_writedata[SADC_CFG_CLK_LSB +:
                                           SADC_CLK_W];
            end
            if (avs_byteenable[1]) begin
                mask_ff <= avs_writedata[SADC_CFG_MASK_BIT];
            end
        end
    end

    // ==========================================================
    // Conversion clock divider
    always_comb begin
        unique case (clksel_ff)
            3'h0:    div_limit = 6'h01;
            3'h4:    div_limit = 6'h03;
            3'h1:    div_limit = 6'h07;
            3'h5:    div_limit = 6'h0F;
            3'h2:    div_limit = 6'h1F;
            3'h6:    div_limit = 6'h3F;
            default: div_limit = 6'h00;
        endcase
    end

    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            div_ff <= 6'h00;
        end else if (!sar_hold || div_ff >= div_limit) begin
            div_ff <= 6'h00;
        end else begin
            div_ff <= div_ff + 6'h01;
        end
    end

    // RC source is an external tick; it keeps running in sleep
    assign tick = (clksel_ff[1:0] == SADC_CLK_RC_LOW) ? rc_clock_tick
                  : (div_ff == div_limit);

    // Eleven periods: one sample plus ten bit decisions
    sadc_sar #(
        .RES_W (RES_W)
    ) u_sar (
        .clk       (clk),
        .reset     (reset),
        .start     (start),
        .tick      (tick),
        .comp_high (comp_high),
        .dac_trial (dac_trial),
        .hold      (sar_hold),
        .done      (sar_done),
        .code      (sar_code)
    );

    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            result_ff <= '0;
        end else if (sar_done) begin
            result_ff <= sar_code;
        end
    end

    // ==========================================================
    // Done flag: set wins over write-one-to-clear
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            flag_ff <= 1'b0;
        end else if (sar_done) begin
            flag_ff <= 1'b1;
        end else if (wr_stat && avs_writedata[SADC_STAT_DONE_BIT]) begin
            flag_ff <= 1'b0;
        end
    end

    // Level output also serves as the sleep wake request
    assign irq = flag_ff && mask_ff;

    // Single mux into the one sample-hold
    assign analog_ctrl.channel_select = chan_ff;
    assign analog_ctrl.pos_ref_select = pref_ff;
    assign analog_ctrl.neg_ref_select = nref_ff;
    assign analog_ctrl.sample_hold    = sar_hold;

endmodule : sadc_ctrl
`default_nettype wire

//--- testbench/sadc_ctrl_sva.sv
/*
 Port checker for the converter control block.
 Assumes binding to sadc_ctrl; one clock, async high reset.
*/
`timescale 1ns/1ns
`default_nettype none
module sadc_ctrl_chk
    import sadc_pkg::*;
(
    input wire logic         clk,
    input wire logic         reset,
    input wire logic         avs_read,
    input wire logic         avs_write,
    input wire logic [31:0]  avs_readdata,
    input wire logic         avs_waitrequest,
    input wire logic         low_voltage_part,
    input wire sadc_analog_t analog_ctrl,
    input wire logic         irq
);
    // ==========================================================
    // Properties
    default clocking @(posedge clk); endclocking
    default disable iff (reset);
    wire logic req = avs_read | avs_write;
    wire logic hold = analog_ctrl.sample_hold;

    first_wait_a: assert property (req && !$past(req) |-> avs_waitrequest)
        else $error("request accepted without wait state");
    one_wait_a: assert property (req && avs_waitrequest |=> !avs_waitrequest)
        else $error("wait state longer than one cycle");
    rd_hold_a: assert property (
        !$stable(avs_readdata) |-> $past(avs_read))
        else $error("read data moved without a read");
    chan_cause_a: assert property (
        !$stable(analog_ctrl.channel_select) |-> $past(avs_write))
        else $error("channel moved without a write");
    ref_cause_a: assert property (
        !$stable({analog_ctrl.pos_ref_select, analog_ctrl.neg_ref_select})
        |-> $past(avs_write)) else $error("reference moved without a write");
    lowv_pref_a: assert property (
        $past(low_voltage_part) && !$stable(analog_ctrl.pos_ref_select)
        |-> analog_ctrl.pos_ref_select != SADC_PREF_FVR4)
        else $error("high fixed reference on low voltage part");
    hold_min_a: assert property ($rose(hold) |-> hold[*8])
        else $error("conversion shorter than eight cycles");
    start_cause_a: assert property ($rose(hold) |->
        $past(avs_write) || $past(avs_write, 2) || $past(avs_write, 3))
        else $error("conversion started without a write");
    irq_rise_a: assert property ($rose(irq) |-> $past(hold)
        || $past(hold, 2) || $past(avs_write) || $past(avs_write, 2))
        else $error("interrupt without completion or write");
    irq_fall_a: assert property (
        $fell(irq) |-> $past(avs_write) || $past(avs_write, 2))
        else $error("interrupt dropped without a write");
endmodule : sadc_ctrl_chk

bind sadc_ctrl sadc_ctrl_chk chk_u (.clk(clk), .reset(reset),
    .avs_read(avs_read), .avs_write(avs_write), .irq(irq),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
    .low_voltage_part(low_voltage_part), .analog_ctrl(analog_ctrl));
`default_nettype wire

//--- testbench/sadc_ana_model.sv
/*
 Behavioural analog side: input levels per channel and comparator.
 Assumes the trial code is compared against the held level.
*/
`timescale 1ns/1ns
`default_nettype none
module sadc_ana_model
    import sadc_pkg::*;
(
    input wire logic                  clk,
    input wire sadc_analog_t          analog_ctrl,
    input wire logic [SADC_RES_W-1:0] dac_trial,
    output logic                      comp_high
);
    // ==========================================================
    // Levels: ground and the zeroed DAC both read as zero
    logic [SADC_RES_W-1:0] level;
    logic                  junk_ff = 1'b0;
    always_comb begin
        if (analog_ctrl.channel_select == SADC_CH_GND ||
            analog_ctrl.channel_select == SADC_CH_DAC) begin
            level = '0;
        end else begin
            // Pin channels taken as set to analog input by software
            level = {analog_ctrl.channel_select, 4'h9};
        end
    end
    // Outside a hold the output is meaningless, so it keeps toggling
    always @(posedge clk) begin
        junk_ff <= !junk_ff;
    end
    assign comp_high = analog_ctrl.sample_hold ? (level >= dac_trial)
                                               : junk_ff;
endmodule : sadc_ana_model
`default_nettype wire

//--- testbench/sar_adc_config_control_tb.sv
/*
 Self-checking bench: registers, references, channels, conversions.
 Assumes the one-wait-state Avalon slave described by the designer.
*/
`timescale 1ns/1ns
`default_nettype none
module sar_adc_config_control_tb;
    import sadc_pkg::*;
    logic clk = 0, reset = 1, avs_read = 0, avs_write = 0;
    logic rc_clock_tick = 0, low_voltage_part = 0, hold_q = 0;
    logic [3:0] avs_address = '0;
    logic [31:0] avs_writedata = '0, avs_readdata, v, ex;
    logic avs_waitrequest, comp_high, irq;
    logic [9:0] dac_trial;
    sadc_analog_t analog_ctrl;
    int fail_count = 0, cmp_count = 0, hcnt = 0, rcc = 0, n;
    logic [2:0] cs_t [7] = '{3'h0, 3'h4, 3'h1, 3'h5, 3'h2, 3'h6, 3'h3};
    int dv_t [7] = '{2, 4, 8, 16, 32, 64, 5};
    logic [5:0] ch_t [7] = '{6'h2A, 6'h3F, 6'h15, 6'h3D, 6'h3E, 6'h07, 6'h3C};
    logic [5:0] ch_l [6] = '{6'h00, 6'h05, 6'h3C, 6'h3D, 6'h3E, 6'h3F};

    sadc_ctrl dut_u (.clk(clk), .reset(reset), .avs_address(avs_address),
        .avs_read(avs_read), .avs_write(avs_write),
        .avs_writedata(avs_writedata), .avs_byteenable(4'hF),
        .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
        .rc_clock_tick(rc_clock_tick), .comp_high(comp_high),
        .low_voltage_part(low_voltage_part), .analog_ctrl(analog_ctrl),
        .dac_trial(dac_trial), .irq(irq));
    sadc_ana_model ana_u (.clk(clk), .analog_ctrl(analog_ctrl),
        .dac_trial(dac_trial), .comp_high(comp_high));

    always #4 clk = !clk;
    // ==========================================================
    // Free running RC pulse and hold length measure
    always @(posedge clk) begin
        rcc <= (rcc == 4) ? 0 : rcc + 1;
        rc_clock_tick <= (rcc == 4);
        hold_q <= analog_ctrl.sample_hold;
        if (analog_ctrl.sample_hold) hcnt <= hold_q ? hcnt + 1 : 1;
    end

    function automatic logic [31:0] ctl(logic on, logic go, logic [5:0] c);
        return (32'(c) << SADC_CTRL_CH_LSB) | (32'(go) << 1) | 32'(on);
    endfunction : ctl
    function automatic logic [31:0] cfg(logic [1:0] p, logic q,
                                        logic [2:0] c, logic m);
        return 32'(p) | (32'(q) << SADC_CFG_NREF_BIT)
            | (32'(c) << SADC_CFG_CLK_LSB) | (32'(m) << SADC_CFG_MASK_BIT);
    endfunction : cfg
    task automatic chk(string nm, logic [31:0] e, logic [31:0] g);
        cmp_count++;
        if (g !== e) begin
            fail_count++;
            $display("BAD %s expected %h seen %h", nm, e, g);
        end
    endtask : chk
    // Request held until the rising edge that samples waitrequest low
    task automatic bus(logic wr, logic [3:0] a, logic [31:0] d);
        n = 0;
        avs_address <= a;
        avs_writedata <= d;
        avs_write <= wr;
        avs_read <= !wr;
        do begin @(posedge clk); n++; end
        while (avs_waitrequest !== 1'b0 && n < 50);
        v = avs_readdata;
        avs_write <= 1'b0;
        avs_read <= 1'b0;
        @(posedge clk);
        if (n >= 50) fail_count++;
    endtask : bus
    task automatic rd(string nm, logic [3:0] a, logic [31:0] e);
        bus(1'b0, a, '0);
        chk(nm, e, v);
    endtask : rd
    task automatic wait_sig(logic on_irq, logic lv);
        n = 0;
        while ((on_irq ? irq : analog_ctrl.sample_hold) !== lv
               && n < 2000) begin
            @(posedge clk);
            n++;
        end
        if (n >= 2000) fail_count++;
    endtask : wait_sig
    task results;
        $display("comparisons %0d mismatches %0d", cmp_count, fail_count);
        if (fail_count == 0 && cmp_count > 0) $display("TEST PASSED");
        else $display("TEST FAILED");
        $finish;
    endtask : results

    initial begin
        repeat (20000) @(posedge clk);
        fail_count++;
        results();
    end

    initial begin
        repeat (10) @(posedge clk);
        reset <= 1'b0;
        @(posedge clk);
        for (int a = 0; a < 16; a += 4) rd("reset value", 4'(a), '0);
        chk("irq", 0, irq);
        bus(1'b1, 4'h1, 32'hFFFF_FFFF);
        rd("unmapped", 4'h1, '0);
        for (int p = 0; p < 4; p++) begin
            bus(1'b1, SADC_OFF_CFG, cfg(2'(p), p[0], 3'h0, 1'b0));
            rd("cfg", SADC_OFF_CFG, cfg(2'(p), p[0], 3'h0, 1'b0));
            chk("pref", p, analog_ctrl.pos_ref_select);
            chk("nref", p % 2, analog_ctrl.neg_ref_select);
        end
        low_voltage_part <= 1'b1;
        bus(1'b1, SADC_OFF_CFG, cfg(SADC_PREF_FVR4, 1'b0, 3'h0, 1'b0));
        chk("low pref", SADC_PREF_FVR2, analog_ctrl.pos_ref_select);
        low_voltage_part <= 1'b0;
        foreach (ch_l[i]) begin
            bus(1'b1, SADC_OFF_CTRL, ctl(0, 0, ch_l[i]));
            chk("channel", ch_l[i], analog_ctrl.channel_select);
            rd("ctrl", SADC_OFF_CTRL, ctl(0, 0, ch_l[i]));
        end
        bus(1'b1, SADC_OFF_CTRL, ctl(1, 1, 6'h05));
        repeat (30) @(posedge clk);
        chk("hold", 0, analog_ctrl.sample_hold);
        rd("status", SADC_OFF_STATUS, '0);
        rd("ctrl go", SADC_OFF_CTRL, ctl(1, 0, 6'h05));
        foreach (cs_t[i]) begin
            bus(1'b1, SADC_OFF_CFG, cfg(2'h1, 1'b0, cs_t[i], 1'b1));
            bus(1'b1, SADC_OFF_CTRL, ctl(1, 0, ch_t[i]));
            repeat (20) @(posedge clk);
            bus(1'b1, SADC_OFF_CTRL, ctl(1, 1, ch_t[i]));
            wait_sig(1'b1, 1'b1);
            chk("irq", 1, irq);
            chk("len", 1, hcnt >= 11 * dv_t[i] - 4
                && hcnt <= 11 * dv_t[i]);
            ex = (ch_t[i] >= 6'h3D && ch_t[i] != 6'h3E) ? '0
                 : {ch_t[i], 4'h9};
            rd("result", SADC_OFF_RESULT, ex);
            chk("trial", ex, 32'(dac_trial));
            rd("status", SADC_OFF_STATUS, 32'h1);
            rd("ctrl go", SADC_OFF_CTRL, ctl(1, 0, ch_t[i]));
            bus(1'b1, SADC_OFF_STATUS, 32'h1);
            chk("irq clr", 0, irq);
        end
        bus(1'b1, SADC_OFF_CFG, cfg(2'h1, 1'b0, 3'h0, 1'b0));
        bus(1'b1, SADC_OFF_CTRL, ctl(1, 1, 6'h15));
        wait_sig(1'b0, 1'b0);
        repeat (4) @(posedge clk);
        chk("irq masked", 0, irq);
        rd("status", SADC_OFF_STATUS, 32'h1);
        bus(1'b1, SADC_OFF_CFG, cfg(2'h1, 1'b0, 3'h0, 1'b1));
        chk("irq unmask", 1, irq);
        bus(1'b1, SADC_OFF_STATUS, 32'h1);
        chk("irq clr", 0, irq);
        results();
    end
endmodule : sar_adc_config_control_tb
`default_nettype wire
